// file: design/srl_latch_top.sv
// Set/reset latch with selectable sources, firmware pulses, a pulse
// divider and two pin outputs, reached over APB.
// Assumes pins and comparator levels are asynchronous to mclk_in.
//
// Contract
// [RL1] Latch follows its set and reset inputs with no wait beyond sampling.
// [RL2] All set and reset inputs are active high.
// [RL3] Set and reset both high puts the latch in reset.
// [RL4] Firmware set/reset bits give one pulse, clear themselves, read zero.
// [RL5] latch_enable one runs the latch, zero stops it.
// [RL6] Divider codes 0 to 7 divide the clock by 4 up to 512.
// [RL7] Firmware changes the divider only while the latch is disabled.
// [RL8] q_pin_enable routes the true output to q_pin.
// [RL9] qbar_pin_enable routes the inverted output to qbar_pin.
// [RL10] Firmware sets each chosen pin's direction to output.
// [RL11] Reset leaves latch state unknown; firmware sets it before pins.
// [RL12] ext_irq_set_enable lets a high interrupt pin set the latch.
// [RL13] clock_set_enable lets divider ticks set the latch.
// [RL14] Comparator set enables let each comparator output set the latch.
// [RL15] ext_irq_reset_enable lets a high interrupt pin reset the latch.
// [RL16] clock_reset_enable lets divider ticks reset the latch.
// [RL17] Comparator reset enables let each comparator reset the latch.
// [RL18] Combined set and reset are OR of enabled sources and pulses.
`timescale 1ns/10ps
`default_nettype none
module srl_latch_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [srl_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [srl_pkg::APB_DATA_W-1:0] pwdata_in,
  output logic [srl_pkg::APB_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Latch sources
  input wire logic comparator1_in,
  input wire logic comparator2_in,
  input wire logic ext_irq_pin1_in,
  // Pins
  output logic q_pin_out,
  output logic q_pin_oe_out,
  output logic qbar_pin_out,
  output logic qbar_pin_oe_out
);

  // Registers
  logic [srl_pkg::REG_W-1:0] latch_control;
  logic [srl_pkg::REG_W-1:0] latch_source_enables;
  logic firmware_set_pulse;
  logic firmware_reset_pulse;
  logic latch_q;

  // Synchronised inputs
  logic [2:0] raw_levels;
  logic [2:0] sync_levels;
  logic cmp1;
  logic cmp2;
  logic ext_irq_pin1;

  assign raw_levels = {ext_irq_pin1_in, comparator2_in, comparator1_in};

  srl_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(raw_levels),
    .q_out(sync_levels)
  );

  assign cmp1 = sync_levels[0];
  assign cmp2 = sync_levels[1];
  assign ext_irq_pin1 = sync_levels[2];

  // Control fields
  logic latch_enable;
  logic q_pin_enable;
  logic qbar_pin_enable;
  logic divided_pulse_clock;

  assign latch_enable = latch_control[srl_pkg::CTL_ENABLE_BIT];
  assign q_pin_enable = latch_control[srl_pkg::CTL_QPIN_BIT];
  assign qbar_pin_enable = latch_control[srl_pkg::CTL_QBAR_BIT];

  // Pulse divider
  srl_div_if div_bus ();

  assign div_bus.sel =
    latch_control[srl_pkg::CTL_DIV_MSB:srl_pkg::CTL_DIV_LSB]; // [RL6]
  // Divider sleeps while the latch is off; saves toggling
  assign div_bus.run = latch_enable;
  assign divided_pulse_clock = div_bus.tick;

  srl_divider #(
    .CNT_W(srl_pkg::DIV_CNT_W)
  ) u_divider (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .div_port(div_bus)
  );

  // Source selection, all active high
  logic set_irq;
  logic set_clk;
  logic set_cmp2;
  logic set_cmp1;
  logic reset_irq;
  logic reset_clk;
  logic reset_cmp2;
  logic reset_cmp1;
  logic combined_set;
  logic combined_reset;

  assign set_irq = ext_irq_pin1 &
    latch_source_enables[srl_pkg::SRC_IRQ_SET_BIT]; // [RL12]
  assign set_clk = divided_pulse_clock &
    latch_source_enables[srl_pkg::SRC_CLK_SET_BIT]; // [RL13]
  assign set_cmp2 = cmp2 &
    latch_source_enables[srl_pkg::SRC_CMP2_SET_BIT]; // [RL14]
  assign set_cmp1 = cmp1 &
    latch_source_enables[srl_pkg::SRC_CMP1_SET_BIT]; // [RL14]
  assign reset_irq = ext_irq_pin1 &
    latch_source_enables[srl_pkg::SRC_IRQ_RESET_BIT]; // [RL15]
  assign reset_clk = divided_pulse_clock &
    latch_source_enables[srl_pkg::SRC_CLK_RESET_BIT]; // [RL16]
  assign reset_cmp2 = cmp2 &
    latch_source_enables[srl_pkg::SRC_CMP2_RESET_BIT]; // [RL17]
  assign reset_cmp1 = cmp1 &
    latch_source_enables[srl_pkg::SRC_CMP1_RESET_BIT]; // [RL17]

  assign combined_set = set_irq | set_clk | set_cmp2 | set_cmp1 |
    firmware_set_pulse; // [RL18] [RL2]
  assign combined_reset = reset_irq | reset_clk | reset_cmp2 |
    reset_cmp1 | firmware_reset_pulse; // [RL18] [RL2]

  // Reset dominates; otherwise set, otherwise hold
  logic next_latch_q;

  assign next_latch_q = combined_reset ? 1'b0 :
    (combined_set ? 1'b1 : latch_q); // [RL3]

  // Latch state has no reset on purpose: firmware must set it up
  always_ff @(posedge mclk_in)
  begin
    if (latch_enable) // [RL5]
    begin
      latch_q <= next_latch_q; // [RL1] [RL11]
    end
  end

  // Pin outputs; enables low from reset keep unknown state off the pins
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      q_pin_out <= 1'b0;
      q_pin_oe_out <= 1'b0;
      qbar_pin_out <= 1'b0;
      qbar_pin_oe_out <= 1'b0;
    end
    else
    begin
      q_pin_oe_out <= q_pin_enable & latch_enable; // [RL8]
      q_pin_out <= q_pin_enable & latch_enable & latch_q; // [RL8]
      qbar_pin_oe_out <= qbar_pin_enable & latch_enable; // [RL9]
      qbar_pin_out <= qbar_pin_enable & latch_enable & ~latch_q; // [RL9]
    end
  end

  // APB decode
  logic setup_phase;
  logic access_done;
  logic hit_control;
  logic hit_sources;
  logic hit_status;
  logic addr_mapped;
  logic wr_control;
  logic wr_sources;
  logic [srl_pkg::REG_W-1:0] status_word;
  logic [srl_pkg::REG_W-1:0] read_mux;

  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign hit_control = paddr_in == srl_pkg::OFF_CONTROL;
  assign hit_sources = paddr_in == srl_pkg::OFF_SOURCES;
  assign hit_status = paddr_in == srl_pkg::OFF_STATUS;
  assign addr_mapped = hit_control | hit_sources | hit_status;
  assign wr_control = access_done & pwrite_in & hit_control;
  assign wr_sources = access_done & pwrite_in & hit_sources;

  always_comb
  begin
    status_word = '0;
    status_word[srl_pkg::STAT_Q_BIT] = latch_q;
    status_word[srl_pkg::STAT_QBAR_BIT] = ~latch_q;
  end

  // Pulse bits are never stored, so they read as zero
  assign read_mux = hit_control ? latch_control :
    (hit_sources ? latch_source_enables :
    (hit_status ? status_word : '0)); // [RL4]

  // Bus answer: ready in the first access cycle
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
    end
    else
    begin
      pready_out <= setup_phase;
      pslverr_out <= setup_phase & ~addr_mapped;
      prdata_out <= setup_phase ? 32'(read_mux) : '0;
    end
  end

  // Register writes
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      latch_control <= srl_pkg::RST_CONTROL;
      latch_source_enables <= srl_pkg::RST_SOURCES;
    end
    else
    begin
      if (wr_control)
      begin
        latch_control <= {pwdata_in[7:2], 2'b00}; // [RL4]
      end
      if (wr_sources)
      begin
        latch_source_enables <= pwdata_in[7:0];
      end
    end
  end

  // Firmware pulses last one cycle and clear themselves
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      firmware_set_pulse <= 1'b0;
      firmware_reset_pulse <= 1'b0;
    end
    else
    begin
      firmware_set_pulse <= wr_control &
        pwdata_in[srl_pkg::CTL_SET_PULSE_BIT]; // [RL4]
      firmware_reset_pulse <= wr_control &
        pwdata_in[srl_pkg::CTL_RESET_PULSE_BIT]; // [RL4]
    end
  end

endmodule
`default_nettype wire

// file: inc/srl_pkg.sv
// Constants shared by the set/reset latch block: register map, field
// positions, reset values and pulse divider sizing.
// Assumes a 32-bit APB register bus and a single 20 MHz clock.
package srl_pkg;

  // Register bus
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam int REG_W = 8;

  // Register byte offsets
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_SOURCES = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;

  // latch_control fields
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_DIV_MSB = 6;
  localparam int CTL_DIV_LSB = 4;
  localparam int CTL_QPIN_BIT = 3;
  localparam int CTL_QBAR_BIT = 2;
  localparam int CTL_SET_PULSE_BIT = 1;
  localparam int CTL_RESET_PULSE_BIT = 0;

  // latch_source_enables fields
  localparam int SRC_IRQ_SET_BIT = 7;
  localparam int SRC_CLK_SET_BIT = 6;
  localparam int SRC_CMP2_SET_BIT = 5;
  localparam int SRC_CMP1_SET_BIT = 4;
  localparam int SRC_IRQ_RESET_BIT = 3;
  localparam int SRC_CLK_RESET_BIT = 2;
  localparam int SRC_CMP2_RESET_BIT = 1;
  localparam int SRC_CMP1_RESET_BIT = 0;

  // latch_status fields
  localparam int STAT_Q_BIT = 0;
  localparam int STAT_QBAR_BIT = 1;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_SOURCES = 8'h00;

  // Pulse divider: code 0 divides by 2**2, code 7 by 2**9
  localparam int DIV_SEL_W = 3;
  localparam logic [3:0] DIV_MIN_SHIFT = 4'h2;
  localparam int DIV_CNT_W = 9;

endpackage

// file: inc/srl_div_if.sv
// Carrier between the latch top and its pulse divider.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface srl_div_if;
  logic [srl_pkg::DIV_SEL_W-1:0] sel;
  logic run;
  logic tick;

  modport ctrl (output sel, output run, input tick);
  modport div (input sel, input run, output tick);
endinterface
`default_nettype wire

// file: design/srl_sync.sv
// Two-stage synchroniser for levels coming from pins or analog blocks.
// Assumes inputs are asynchronous to mclk_in.
`timescale 1ns/10ps
`default_nettype none
module srl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// file: design/srl_divider.sv
// Pulse divider: one-cycle tick every 4 to 512 clock cycles.
// Assumes the select is held steady while running.
`timescale 1ns/10ps
`default_nettype none
module srl_divider #(
  parameter int CNT_W = srl_pkg::DIV_CNT_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Control and tick
  srl_div_if.div div_port
);
  logic [CNT_W-1:0] count;
  logic [3:0] shift;
  logic [CNT_W-1:0] mask;
  logic wrap;

  assign shift = 4'(div_port.sel) + srl_pkg::DIV_MIN_SHIFT;
  assign mask = ~({CNT_W{1'b1}} << shift);
  // A select change mid-count can wrap early: a stray tick
  assign wrap = &(count | ~mask); // [RL6]

  always_ff @(posedge mclk_in)
  begin
    if (reset_in || !div_port.run)
    begin
      count <= '0;
      div_port.tick <= 1'b0;
    end
    else
    begin
      count <= count + 1'b1;
      div_port.tick <= wrap; // [RL6]
    end
  end
endmodule
`default_nettype wire

// file: design/srl_latch_top_dummy_guard.sv
`timescale 1ns/10ps

// file: tb/srl_latch_chk.sv
// Checker for the latch top: bus timing, pin gating, firmware pulses.
// Sees only top ports and rebuilds both control registers from writes.
`timescale 1ns/10ps
`default_nettype none
module srl_latch_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Pins
  input wire logic q_pin_out,
  input wire logic q_pin_oe_out,
  input wire logic qbar_pin_out,
  input wire logic qbar_pin_oe_out
);
  logic [7:0] ctl;
  logic [7:0] src;
  logic acc;
  logic wr0;
  assign acc = psel_in & penable_in & pready_out;
  assign wr0 = acc & pwrite_in & (paddr_in == 12'h000);
  // Pulse bits are never kept, so the shadow reads them as zero
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      ctl <= 8'h00;
    else if (wr0)
      ctl <= pwdata_in[7:0] & 8'hfc;
  end
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      src <= 8'h00;
    else if (acc && pwrite_in && paddr_in == 12'h004)
      src <= pwdata_in[7:0];
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  AST_RDY: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  AST_MAP: assert property (pready_out |-> pslverr_out ==
    !(paddr_in inside {12'h000, 12'h004, 12'h008}))
    else $error("error response wrong");
  AST_OEQ: assert property (q_pin_oe_out == $past(ctl[7] & ctl[3]))
    else $error("q drive enable wrong");
  AST_OEN: assert property (qbar_pin_oe_out == $past(ctl[7] & ctl[2]))
    else $error("qbar drive enable wrong");
  AST_OFF: assert property (!q_pin_oe_out |-> !q_pin_out)
    else $error("q pin not idle");
  AST_QB: assert property (q_pin_oe_out && qbar_pin_oe_out |->
    q_pin_out != qbar_pin_out)
    else $error("pins not complementary");
  AST_FWS: assert property (wr0 && (pwdata_in[7:0] & 8'h8b) == 8'h8a
    && src[3:0] == 4'h0 |-> ##3 q_pin_out)
    else $error("set pulse lost");
  AST_FWR: assert property (wr0 && (pwdata_in[7:0] & 8'h89) == 8'h89
    |-> ##3 !q_pin_out)
    else $error("reset pulse lost");
  AST_RDC: assert property (acc && !pwrite_in && paddr_in == 12'h000
    |-> prdata_out == {24'h000000, ctl})
    else $error("control readback wrong");
endmodule
bind srl_latch_top srl_latch_chk u_srl_latch_chk (.mclk_in, .reset_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .pready_out, .pslverr_out, .q_pin_out, .q_pin_oe_out, .qbar_pin_out,
  .qbar_pin_oe_out);
`default_nettype wire

// file: tb/srl_pins_model.sv
// Far side: comparator and interrupt levels, and the two pin wires.
// Assumes the bench requests levels; an undriven pin shows no held value.
`timescale 1ns/10ps
`default_nettype none
module srl_pins_model (
  // Clock and level requests
  input wire logic mclk_in,
  input wire logic [2:0] lv_in,
  // Sources
  output logic comparator1_out,
  output logic comparator2_out,
  output logic ext_irq_pin1_out,
  // Pins
  input wire logic q_pin_in,
  input wire logic q_pin_oe_in,
  input wire logic qbar_pin_in,
  input wire logic qbar_pin_oe_in,
  output logic q_wire_out,
  output logic qbar_wire_out
);
  logic [2:0] lv = 3'h0;
  // Active high levels, changed just after an edge
  always @(posedge mclk_in)
    lv <= lv_in;
  assign {ext_irq_pin1_out, comparator2_out, comparator1_out} = lv;
  // Pin set to output only when enabled, else it floats to the inverse
  assign q_wire_out = q_pin_oe_in ? q_pin_in : ~q_pin_in;
  assign qbar_wire_out = qbar_pin_oe_in ? qbar_pin_in : ~qbar_pin_in;
endmodule
`default_nettype wire

// file: tb/srl_latch_top_tb.sv
// Bench for the latch top: APB master, random sources, divider periods.
// Assumes the pins model sits on the source and pin side.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin err_total++; \
  $display("wrong value at %0t: %h not %h", $time, g, x); end end
module srl_latch_top_tb;
  logic mclk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, pready_out, pslverr_out, e, mq;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, r;
  logic comparator1_in, comparator2_in, ext_irq_pin1_in, q_pin_out;
  logic q_pin_oe_out, qbar_pin_out, qbar_pin_oe_out, qw, qbw;
  logic [2:0] lv = 0, t3;
  logic [7:0] s;
  int err_total = 0, comparisons = 0, cyc = 0, i, c, t, t2;
  srl_latch_top u_srl_latch_top (.mclk_in, .reset_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .comparator1_in, .comparator2_in,
    .ext_irq_pin1_in, .q_pin_out, .q_pin_oe_out, .qbar_pin_out,
    .qbar_pin_oe_out);
  srl_pins_model u_srl_pins_model (.mclk_in, .lv_in(lv),
    .comparator1_out(comparator1_in), .comparator2_out(comparator2_in),
    .ext_irq_pin1_out(ext_irq_pin1_in), .q_pin_in(q_pin_out),
    .q_pin_oe_in(q_pin_oe_out), .qbar_pin_in(qbar_pin_out),
    .qbar_pin_oe_in(qbar_pin_oe_out), .q_wire_out(qw),
    .qbar_wire_out(qbw));
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) cyc <= cyc + 1;
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Ready is read at the rising edge, before that edge's updates land,
  // so the request is held until the edge that completes it
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk_in);
      if (pready_out === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      end_sim;
    end
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic chk_q;
    repeat (8) @(negedge mclk_in);
    `CHK(qw, mq)
    `CHK(qbw, ~mq)
    apb(0, 12'h008, 0);
    `CHK(r, {30'h0, ~mq, mq})
  endtask
  // Period is timed between two one-cycle drops of the q pin
  task automatic fall(output int tt);
    logic last;
    int n;
    last = 1'b0;
    for (n = 0; n < 1200 && !(last === 1'b1 && q_pin_out === 1'b0); n++)
    begin
      last = q_pin_out;
      @(negedge mclk_in);
    end
    if (n == 1200)
    begin
      err_total++;
      end_sim;
    end
    tt = cyc;
  endtask
  initial
  begin
    void'($urandom(77707));
    repeat (4) @(posedge mclk_in);
    reset_in <= 1'b0;
    apb(0, 12'h000, 0);
    `CHK(r, 32'h0)
    apb(0, 12'h004, 0);
    `CHK(r, 32'h0)
    apb(0, 12'h00c, 0);
    `CHK(e, 1'b1)
    apb(1, 12'h000, 32'h81);
    apb(1, 12'h000, 32'h8c);
    mq = 0;
    chk_q;
    apb(1, 12'h000, 32'h8e);
    mq = 1;
    chk_q;
    apb(1, 12'h000, 32'h8f);
    mq = 0;
    chk_q;
    apb(0, 12'h000, 0);
    `CHK(r, 32'h8c)
    for (i = 0; i < 40; i++)
    begin
      s = 8'($urandom) & 8'hbb;
      t3 = 3'($urandom);
      apb(1, 12'h004, {24'h0, s});
      lv <= t3;
      if ((t3 & {s[3], s[1], s[0]}) != 0)
        mq = 0;
      else if ((t3 & {s[7], s[5], s[4]}) != 0)
        mq = 1;
      chk_q;
      lv <= 3'h0;
      repeat (4) @(posedge mclk_in);
    end
    apb(1, 12'h000, 32'h0c);
    apb(1, 12'h004, 32'hbb);
    lv <= 3'h7;
    repeat (8) @(posedge mclk_in);
    apb(0, 12'h008, 0);
    `CHK(r, {30'h0, ~mq, mq})
    apb(1, 12'h004, 32'h14);
    lv <= 3'h1;
    for (c = 0; c < 8; c++)
    begin
      apb(1, 12'h000, 32'h0);
      apb(1, 12'h000, {24'h0, 1'b1, 3'(c), 4'h8});
      fall(t);
      fall(t2);
      `CHK(t2 - t, 4 << c)
    end
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h004, 32'h40);
    lv <= 3'h0;
    apb(1, 12'h000, 32'h8d);
    mq = 1;
    chk_q;
    end_sim;
  end
endmodule
`default_nettype wire
